// ---- bench/general_and_free_running_timers_tb.sv ----
// self-checking bench of the timer block through its host pins
`timescale 1ns/10ps
module general_and_free_running_timers_tb;
  import timer_regs_pkg::*;
  localparam logic [15:0] DIV = 16'h0002;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic bus16 = 1'b0;
  logic cs_n, rd_n, wr_n, oe, ev;
  logic [6:0] addr;
  logic [31:0] wdata, rdata, d, v0, e, held;
  int error_cnt = 0;
  int tests_run = 0;
  int t, t0, n;
  bit ok;
  host_model host_model_inst (.mclk_in(mclk_in), .rdata_in(rdata), .oe_in(oe), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .data_out(wdata));
  gp_timer_block #(.TICK_DIV(DIV)) gp_timer_block_inst (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .host_addr_in(addr), .host_data_in(wdata),
    .bus16_mode_in(bus16), .host_data_out(rdata), .host_data_oe_out(oe), .timer_event_out(ev));
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic get(input logic [7:0] ofs);
    host_model_inst.rd(ofs, d, t, ok);
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: read stalled", $time);
      conclude();
    end
  endtask : get
  task automatic wait_ev(output int c);
    c = 0;
    do begin
      @(posedge mclk_in);
      c++;
    end while (ev !== 1'b1 && c < 200);
    if (c >= 200) begin
      error_cnt++;
      $display("unexpected at %0t: no timer event", $time);
      conclude();
    end
  endtask : wait_ev
  initial begin
    repeat (4) @(posedge mclk_in);
    #2;
    reset_n_in = 1'b1;
    get(OFS_CONFIG);
    chk(d, 32'h0000_ffff);
    get(OFS_COUNT);
    chk(d, 32'h0000_ffff);
    get(OFS_FREE);
    v0 = d;
    t0 = t;
    chk({31'h0, v0 < 32'h0000_0040}, 32'h0000_0001);
    host_model_inst.wr(OFS_FREE, 32'h1234_5678);
    host_model_inst.wr(OFS_COUNT, 32'h0000_0005);
    get(OFS_COUNT);
    chk(d, 32'h0000_ffff);
    get(OFS_FREE);
    chk(d, v0 + 32'(t - t0));
    get(8'h80);
    chk(d, 32'h0000_0000);
    host_model_inst.wr(OFS_CONFIG, 32'h2000_0003);
    get(OFS_CONFIG);
    chk(d, 32'h2000_0003);
    wait_ev(n);
    wait_ev(n);
    chk(32'(n), 32'h0000_0004 * 32'(DIV));
    wait_ev(n);
    chk(32'(n), 32'h0000_0004 * 32'(DIV));
    host_model_inst.wr(OFS_CONFIG, 32'h0000_1234);
    get(OFS_CONFIG);
    chk(d, 32'h0000_ffff);
    get(OFS_COUNT);
    held = d;
    chk({31'h0, held <= 32'h0000_0003}, 32'h0000_0001);
    get(OFS_COUNT);
    chk(d, held);
    @(posedge mclk_in);
    #2;
    bus16 = 1'b1;
    repeat (4) @(posedge mclk_in);
    get(OFS_FREE);
    e = v0 + 32'(t - t0);
    chk(d, {16'h0000, e[15:0]});
    get(8'h9e);
    chk(d, {16'h0000, e[31:16]});
    get(OFS_FREE);
    e = v0 + 32'(t - t0);
    chk(d, {16'h0000, e[15:0]});
    get(OFS_FREE);
    chk(d, {16'h0000, e[15:0]});
    // half-word config writes: low half preload, high half run bit
    host_model_inst.wr(OFS_CONFIG, 32'h0000_0001);
    host_model_inst.wr(8'h8e, 32'h0000_2000);
    get(OFS_CONFIG);
    chk(d, 32'h0000_0001);
    get(8'h8e);
    chk(d, 32'h0000_2000);
    wait_ev(n);
    wait_ev(n);
    chk(32'(n), 32'h0000_0002 * 32'(DIV));
    host_model_inst.wr(8'h8e, 32'h0000_0000);
    get(OFS_CONFIG);
    chk(d, 32'h0000_ffff);
    get(8'h8e);
    chk(d, 32'h0000_0000);
    conclude();
  end
endmodule : general_and_free_running_timers_tb

// ---- bench/host_model.sv ----
// host cpu model driving the sram-like register pins
`timescale 1ns/10ps
module host_model (
  input wire logic mclk_in,
  input wire logic [31:0] rdata_in,
  input wire logic oe_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [6:0] addr_out,
  output logic [31:0] data_out
);
  int cyc = 0;
  always @(posedge mclk_in) cyc <= cyc + 1;
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 7'h00;
    data_out = 32'h5a5a_a5a5;
  end
  task automatic rd(input logic [7:0] ofs, output logic [31:0] d, output int t, output bit ok);
    ok = 1'b0;
    @(posedge mclk_in);
    #2;
    t = cyc;
    addr_out = ofs[7:1];
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge mclk_in);
      ok = (oe_in === 1'b1);
    end
    d = rdata_in;
    #2;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    repeat (4) @(posedge mclk_in);
  endtask : rd
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    @(posedge mclk_in);
    #2;
    addr_out = ofs[7:1];
    data_out = d;
    cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    repeat (4) @(posedge mclk_in);
    #2;
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    repeat (3) @(posedge mclk_in);
    #2;
    data_out = ~d;
    repeat (3) @(posedge mclk_in);
  endtask : wr
endmodule : host_model

// ---- design/free_run_counter.sv ----
// free-running thirty-two-bit cycle counter
`timescale 1ns/10ps
module free_run_counter (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  output logic [31:0] count_out
);
  import timer_regs_pkg::*;

  typedef struct packed {
    logic [31:0] count;
  } free_state_t;

  free_state_t st;
  free_state_t next_st;

  // no power-state gating at all, counts in every state (R12)
  always_comb begin
    next_st = st;
    next_st.count = st.count + 32'h0000_0001; // R7 R9
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '{count: FREE_RESET}; // R8 R11
    end else begin
      st <= next_st;
    end
  end

  assign count_out = st.count;

  // helper: cycles since reset release, saturating
  logic [3:0] since_reset;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      since_reset <= 4'h0;
    end else if (since_reset != 4'hf) begin
      since_reset <= since_reset + 4'h1;
    end
  end

  a_free_step: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R7 R9 R12
    since_reset != 4'h0 |-> count_out == $past(count_out) + 32'h0000_0001)
    else $error("free counter did not advance by one");
  a_free_zero_start: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R8 R11
    since_reset <= 4'(FREE_CLEAR_CYCLES) |-> count_out == {28'h000_0000, since_reset})
    else $error("free counter not started from zero after reset");
  c_free_wrap: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    count_out == 32'hffff_ffff ##1 count_out == 32'h0000_0000);
endmodule : free_run_counter

// ---- design/gp_timer_block.sv ----
// general purpose timer and free-running counter behind the sram-like host port
`timescale 1ns/10ps
module gp_timer_block #(
  parameter logic [15:0] TICK_DIV = timer_regs_pkg::TICK_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [6:0] host_addr_in,
  input wire logic [31:0] host_data_in,
  input wire logic bus16_mode_in,
  output logic [31:0] host_data_out,
  output logic host_data_oe_out,
  output logic timer_event_out
);
  import timer_regs_pkg::*;

  // host_addr_in carries address bits 7..1; bit 0 of it is a1
  typedef struct packed {
    logic [2:0] ctl_s1;
    logic [2:0] ctl_s2;
    logic [2:0] ctl_s3;
    logic [6:0] a_s1;
    logic [6:0] a_s2;
    logic [6:0] a_s3;
    logic [31:0] d_s1;
    logic [31:0] d_s2;
    logic [31:0] d_s3;
    logic mode_s1;
    logic mode_s2;
    logic run;
    logic [15:0] preload;
    logic [15:0] count;
    logic [15:0] presc;
    logic event_p;
    logic [31:0] rdata;
    logic oe;
    logic [31:0] snap;
    logic snap_held;
  } state_t;

  localparam state_t RESET_ST = '{
    ctl_s1: 3'h7, ctl_s2: 3'h7, ctl_s3: 3'h7,
    a_s1: 7'h00, a_s2: 7'h00, a_s3: 7'h00,
    d_s1: 32'h0000_0000, d_s2: 32'h0000_0000, d_s3: 32'h0000_0000,
    mode_s1: 1'b0, mode_s2: 1'b0,
    run: 1'b0,
    preload: PRELOAD_RESET,
    count: COUNT_RESET,
    presc: 16'h0000,
    event_p: 1'b0,
    rdata: 32'h0000_0000,
    oe: 1'b0,
    snap: 32'h0000_0000,
    snap_held: 1'b0
  };

  state_t st;
  state_t next_st;
  logic [31:0] free_count;

  free_run_counter u_free (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .count_out(free_count)
  );

  logic rd_act2;
  logic rd_act3;
  logic wr_act2;
  logic wr_act3;
  logic rd_start;
  logic wr_end;
  logic tick;
  logic [7:0] rd_word;
  logic [7:0] wr_word;
  logic mode16;

  always_comb begin
    logic [31:0] full;
    logic new_run;
    logic [15:0] new_load;
    full = 32'h0000_0000;
    new_run = st.run;
    new_load = st.preload;
    next_st = st;
    // pin synchronisers: cs, rd, wr, address, data, bus16 mode
    next_st.ctl_s1 = {cs_n_in, rd_n_in, wr_n_in};
    next_st.ctl_s2 = st.ctl_s1;
    next_st.ctl_s3 = st.ctl_s2;
    next_st.a_s1 = host_addr_in;
    next_st.a_s2 = st.a_s1;
    next_st.a_s3 = st.a_s2;
    next_st.d_s1 = host_data_in;
    next_st.d_s2 = st.d_s1;
    next_st.d_s3 = st.d_s2;
    next_st.mode_s1 = bus16_mode_in;
    next_st.mode_s2 = st.mode_s1;
    next_st.event_p = 1'b0;

    rd_act2 = !st.ctl_s2[2] && !st.ctl_s2[1];
    rd_act3 = !st.ctl_s3[2] && !st.ctl_s3[1];
    wr_act2 = !st.ctl_s2[2] && !st.ctl_s2[0];
    wr_act3 = !st.ctl_s3[2] && !st.ctl_s3[0];
    rd_start = rd_act2 && !rd_act3;
    wr_end = wr_act3 && !wr_act2;
    rd_word = {st.a_s2[6:1], 2'b00};
    wr_word = {st.a_s3[6:1], 2'b00};
    mode16 = st.mode_s2;
    next_st.oe = rd_act2;

    // general timer countdown
    tick = st.run && (st.presc == TICK_DIV - 16'h0001);
    if (st.run) begin
      next_st.presc = tick ? 16'h0000 : st.presc + 16'h0001;
      if (tick) begin
        if (st.count == 16'h0000) begin
          next_st.count = st.preload; // R13
          next_st.event_p = 1'b1; // R5 R13
        end else begin
          next_st.count = st.count - 16'h0001; // R13
        end
      end
    end

    // host read
    if (rd_start) begin
      case (rd_word)
        OFS_CONFIG: full = {2'b00, st.run, 13'h0000, st.preload};
        OFS_COUNT: full = {16'h0000, st.count}; // R4
        OFS_FREE: full = free_count; // R7
        default: full = 32'h0000_0000;
      endcase
      if (mode16 && rd_word == OFS_FREE) begin
        if (st.snap_held) begin
          full = st.snap; // R10
          next_st.snap_held = 1'b0;
        end else begin
          next_st.snap = free_count; // R10
          next_st.snap_held = 1'b1;
        end
      end
      if (mode16) begin
        next_st.rdata = {16'h0000, st.a_s2[0] ? full[31:16] : full[15:0]};
      end else begin
        next_st.rdata = full;
      end
    end

    // host write to config
    if (wr_end && wr_word == OFS_CONFIG) begin
      if (!mode16) begin
        new_run = st.d_s3[EN_BIT]; // R1
        new_load = st.d_s3[LOAD_W-1:0]; // R3
      end else if (st.a_s3[0]) begin
        new_run = st.d_s3[EN_BIT_HIGH_HALF]; // R1
      end else begin
        new_load = st.d_s3[LOAD_W-1:0]; // R3
      end
      next_st.run = new_run;
      next_st.preload = new_load;
      if (new_run && !st.run) begin
        next_st.count = new_load; // R3 R13
        next_st.presc = 16'h0000;
      end
      if (!new_run && st.run) begin
        next_st.preload = PRELOAD_RESET; // R2
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= RESET_ST; // R6
    end else begin
      st <= next_st;
    end
  end

  assign host_data_out = st.rdata;
  assign host_data_oe_out = st.oe;
  assign timer_event_out = st.event_p;

  a_stop_preset: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R2
    $fell(st.run) |-> st.preload == PRELOAD_RESET)
    else $error("preload not forced to all ones on stop");
  a_start_loads: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R1 R3
    $rose(st.run) |-> st.count == st.preload && st.presc == 16'h0000)
    else $error("count not loaded from preload on start");
  a_halted_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R1
    !st.run ##1 !st.run |-> $stable(st.count) && !timer_event_out)
    else $error("halted timer changed its count");
  a_tick_down: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R13
    tick && st.count != 16'h0000 && !wr_end |=> st.count == $past(st.count) - 16'h0001)
    else $error("timer did not count down on tick");
  a_zero_reload: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R5 R13
    tick && st.count == 16'h0000 && !wr_end |=> timer_event_out && st.count == $past(st.preload))
    else $error("timer did not reload and flag at zero");
  a_event_cause: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R5
    timer_event_out |-> $past(tick) && $past(st.count) == 16'h0000)
    else $error("timer event without expiry");
  a_count_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R4
    rd_start && !mode16 && rd_word == OFS_COUNT |=> host_data_out == {16'h0000, $past(st.count)})
    else $error("count register read wrong value");
  a_half_match: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R10
    rd_start && mode16 && rd_word == OFS_FREE && st.snap_held |=>
      host_data_out[15:0] == ($past(st.a_s2[0]) ? $past(st.snap[31:16]) : $past(st.snap[15:0])))
    else $error("second half read does not match captured count");
  a_oe_follows: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R4
    rd_start |=> host_data_oe_out)
    else $error("data not driven during read");
  c_timer_event: cover property (@(posedge mclk_in) disable iff (!reset_n_in) timer_event_out);
  c_stop: cover property (@(posedge mclk_in) disable iff (!reset_n_in) $fell(st.run));
  c_half_pair: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    rd_start && mode16 && rd_word == OFS_FREE && st.snap_held);
endmodule : gp_timer_block

// ---- shared/timer_regs_pkg.sv ----
// register map and timing constants of the general and free-running timers
// Behaviour
// (R1) Writing run-enable one starts the general timer; clearing it halts the timer.
// (R2) A one-to-zero change of run-enable forces the preload field to all ones.
// (R3) Software writes a sixteen-bit preload in config low bits; timer loads it.
// (R4) Read-only count register shows present timer count low; upper bits read zero.
// (R5) The general timer raises an event at intervals set by its configuration.
// (R6) After reset run-enable reads zero; preload and present count read all ones.
// (R7) Thirty-two-bit free-running counter increments every system clock; read only.
// (R8) On reset the free-running counter starts counting from zero.
// (R9) At maximum value the free-running counter wraps to zero and keeps counting.
// (R10) Sixteen-bit bus: first half read captures count; second returns matching half.
// (R11) After reset the free-running counter reaches zero within 160 ns.
// (R12) The free-running counter keeps counting in every power-management state.
// (R13) Running timer counts down per tick from preload; past zero, event and reload.
package timer_regs_pkg;
  localparam logic [7:0] OFS_CONFIG = 8'h8c;
  localparam logic [7:0] OFS_COUNT = 8'h90;
  localparam logic [7:0] OFS_FREE = 8'h9c;
  localparam int EN_BIT = 29;
  localparam int EN_BIT_HIGH_HALF = EN_BIT - 16;
  localparam int LOAD_W = 16;
  localparam logic [15:0] PRELOAD_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'hffff;
  localparam logic [31:0] FREE_RESET = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000;
  localparam logic [15:0] TICK_CYCLES = 16'(TICK_NS / CLK_PERIOD_NS);
  localparam int FREE_CLEAR_NS = 160;
  localparam int FREE_CLEAR_CYCLES = (FREE_CLEAR_NS / CLK_PERIOD_NS < 1) ? 1 : FREE_CLEAR_NS / CLK_PERIOD_NS;
endpackage : timer_regs_pkg
